/* File: rtl/wcm_pkg.sv */
// Shared constants and types for the watchdog and clock monitor.
// Assumes a single 100 MHz bus clock; the watchdog periods are derived from it.
package wcm_pkg;

  // Bus clock rate
  localparam int unsigned CORE_MHZ = 100;

  // Watchdog periods in microseconds, one per select code
  localparam int unsigned WDT_T0_US = 8192;
  localparam int unsigned WDT_T1_US = 32768;
  localparam int unsigned WDT_T2_US = 131070;
  localparam int unsigned WDT_T3_US = 524500;
  localparam logic [31:0] WDT_CYC0 = 32'(WDT_T0_US * CORE_MHZ);
  localparam logic [31:0] WDT_CYC1 = 32'(WDT_T1_US * CORE_MHZ);
  localparam logic [31:0] WDT_CYC2 = 32'(WDT_T2_US * CORE_MHZ);
  localparam logic [31:0] WDT_CYC3 = 32'(WDT_T3_US * CORE_MHZ);

  // Select codes, high bit first
  localparam logic [1:0] SEL_T0 = 2'h0;
  localparam logic [1:0] SEL_T1 = 2'h1;
  localparam logic [1:0] SEL_T2 = 2'h2;

  // Option select write window after reset
  localparam logic [6:0] BOOT_WIN_CYC = 7'h40;

  // Internal reset pulse length, under four cycles
  localparam logic [1:0] RST_PULSE_CYC = 2'h3;

  // Service byte values
  localparam logic [7:0] SVC_ARM = 8'h55;
  localparam logic [7:0] SVC_FIRE = 8'haa;

  // Clock monitor: reference half period and failure threshold
  localparam int unsigned CM_REF_HALF_NS = 50000;
  localparam int unsigned CM_FAIL_KHZ = 100;
  localparam logic [3:0] CM_MIN_CYC = 4'((CM_REF_HALF_NS * CM_FAIL_KHZ) / 1000000);
  localparam logic [3:0] CM_GAP_MAX = 4'hf;

  // Option register fields
  typedef struct packed {
    logic [1:0] sel;
    logic clock_watch_enable;
    logic clock_watch_force_enable;
  } wcm_opt_t;

  // Reset values
  localparam wcm_opt_t OPT_RST = '{sel: 2'h0, clock_watch_enable: 1'b0, clock_watch_force_enable: 1'b0};
  localparam logic DIS_RST = 1'b1;

endpackage : wcm_pkg

/* File: rtl/wcm_timeout_cnt.sv */
// Timeout counter for the watchdog.
// Assumes restart and run come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module wcm_timeout_cnt (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic [31:0] limit_i,
  // Result
  output logic expired_o
);

  logic [31:0] cnt_ff;

  // Counts bus cycles; wraps and flags on the last cycle of the period
  always_ff @(posedge core_clk_i) begin
    if (rst_i || restart_i || !run_i) begin // see R16
      cnt_ff <= 32'h0;
      expired_o <= 1'b0;
    end else if (cnt_ff >= limit_i - 32'h1) begin
      cnt_ff <= 32'h0;
      expired_o <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
      expired_o <= 1'b0;
    end
  end

endmodule : wcm_timeout_cnt
`default_nettype wire

/* File: rtl/wcm_top.sv */
// Watchdog with service sequence, timeout select, disable bit and clock monitor.
// Assumes control strobes come from the core's own clock domain; ref_osc_i is a pin.
// Function
// R1: An enabled watchdog resets the processor when no valid service completes within the period.
// R2: Select 00/01/10/11 gives 8.192, 32.768, 131.07 and 524.5 ms, high bit first.
// R3: The timeout select bits take writes only during the first 64 cycles after reset.
// R4: The disable bit keeps the watchdog idle while set, and clearing it enables it.
// R5: The disable bit starts out set so the watchdog is off until software clears it. The code loads nv_disable_i one cycle after reset.
// R6: The disable bit survives power loss and comes back as last written.
// R7: Software services by writing 55h then aah, with anything in between.
// R8: Both writes land before timeout and storing aah restarts the period.
// R9: The clock monitor does not reset while the bus clock is above 200 kHz.
// R10: The clock monitor always resets below 10 kHz and may reset up to 200 kHz.
// R11: The clock monitor enable bit can be set or cleared at any time.
// R12: The force enable bit resets to 0 and once set keeps the monitor on until reset.
// R13: A stop instruction with the monitor on stops the clock and causes a reset.
// R14: A failure drives reset low under four cycles and records which failure it was.
// R15: An aah write with no 55h since the last service does not restart the period.
// R16: The timeout counter runs on the bus clock and clears on every reset.
`timescale 1ns/1ns
`default_nettype none
module wcm_top #(
  parameter logic [31:0] WDT_CYC0 = wcm_pkg::WDT_CYC0,
  parameter logic [31:0] WDT_CYC1 = wcm_pkg::WDT_CYC1,
  parameter logic [31:0] WDT_CYC2 = wcm_pkg::WDT_CYC2,
  parameter logic [31:0] WDT_CYC3 = wcm_pkg::WDT_CYC3
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Service register write
  input wire logic svc_wr_i,
  input wire logic [7:0] svc_data_i,
  // Option register write
  input wire logic opt_wr_i,
  input wire wcm_pkg::wcm_opt_t opt_wdata_i,
  // Configuration write and non-volatile store
  input wire logic cfg_wr_i,
  input wire logic cfg_disable_i,
  input wire logic nv_disable_i,
  // Clock monitor inputs
  input wire logic stop_i,
  input wire logic ref_osc_i,
  // Cause acknowledge
  input wire logic cause_ack_i,
  // Reset and cause outputs
  output logic rst_n_o,
  output logic wdt_cause_o,
  output logic cm_cause_o,
  // Status
  output wcm_pkg::wcm_opt_t opt_o,
  output logic disable_o,
  output logic svc_armed_o,
  output logic boot_open_o,
  // Non-volatile write-back
  output logic nv_wr_o,
  output logic nv_data_o
);

  wcm_pkg::wcm_opt_t opt_ff;
  logic dis_ff;
  logic cap_done_ff;
  logic armed_ff;
  logic [6:0] boot_cnt_ff;
  logic [1:0] pulse_cnt_ff;
  logic ref_s1_ff;
  logic ref_s2_ff;
  logic ref_s3_ff;
  logic [3:0] cm_gap_ff;
  logic boot_open;
  logic cm_en;
  logic restart;
  logic expired;
  logic wdt_fail;
  logic cm_slow;
  logic cm_fail;
  logic ref_edge;
  logic [31:0] limit;

  // Status outputs straight from their registers
  assign opt_o = opt_ff;
  assign disable_o = dis_ff;
  assign svc_armed_o = armed_ff;

  // Write window flag and monitor enable
  assign boot_open = boot_cnt_ff < wcm_pkg::BOOT_WIN_CYC;
  assign cm_en = opt_ff.clock_watch_enable | opt_ff.clock_watch_force_enable; // see R12

  // Cycles since reset, saturating at the window length
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      boot_cnt_ff <= 7'h0;
      boot_open_o <= 1'b1;
    end else begin
      if (boot_open) begin
        boot_cnt_ff <= boot_cnt_ff + 7'h1;
      end
      boot_open_o <= (boot_cnt_ff + 7'h1) < wcm_pkg::BOOT_WIN_CYC;
    end
  end

  // Option register; select locks after the window, force bit is set-only
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      opt_ff <= wcm_pkg::OPT_RST; // see R12
    end else if (opt_wr_i) begin
      if (boot_open) begin
        opt_ff.sel <= opt_wdata_i.sel; // see R3
      end
      opt_ff.clock_watch_enable <= opt_wdata_i.clock_watch_enable; // see R11
      opt_ff.clock_watch_force_enable <= opt_ff.clock_watch_force_enable | opt_wdata_i.clock_watch_force_enable; // see R12
    end
  end

  // Disable bit: set until the stored value is fetched after reset, then written through
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dis_ff <= wcm_pkg::DIS_RST; // see R5
      cap_done_ff <= 1'b0;
      nv_wr_o <= 1'b0;
      nv_data_o <= wcm_pkg::DIS_RST;
    end else if (!cap_done_ff) begin
      dis_ff <= nv_disable_i; // see R6
      cap_done_ff <= 1'b1;
      nv_wr_o <= 1'b0;
      nv_data_o <= nv_disable_i;
    end else begin
      nv_wr_o <= cfg_wr_i;
      if (cfg_wr_i) begin
        dis_ff <= cfg_disable_i; // see R4
        nv_data_o <= cfg_disable_i; // see R6
      end
    end
  end

  // Service sequence: 55h arms, aah fires only when armed
  assign restart = svc_wr_i && (svc_data_i == wcm_pkg::SVC_FIRE) && armed_ff; // see R15
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      armed_ff <= 1'b0;
    end else if (svc_wr_i && svc_data_i == wcm_pkg::SVC_ARM) begin
      armed_ff <= 1'b1; // see R7
    end else if (restart) begin
      armed_ff <= 1'b0; // see R8
    end
  end

  // Period select, high bit first
  always_comb begin
    case (opt_ff.sel) // see R2
      wcm_pkg::SEL_T0: limit = WDT_CYC0;
      wcm_pkg::SEL_T1: limit = WDT_CYC1;
      wcm_pkg::SEL_T2: limit = WDT_CYC2;
      default: limit = WDT_CYC3;
    endcase
  end

  // Timeout counter; held cleared while disabled
  wcm_timeout_cnt u_cnt (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .run_i(!dis_ff), // see R4
    .restart_i(restart), // see R8
    .limit_i(limit),
    .expired_o(expired)
  );
  assign wdt_fail = expired && !dis_ff; // see R1

  // Reference pin synchroniser plus edge stage
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ref_s1_ff <= 1'b0;
      ref_s2_ff <= 1'b0;
      ref_s3_ff <= 1'b0;
    end else begin
      ref_s1_ff <= ref_osc_i;
      ref_s2_ff <= ref_s1_ff;
      ref_s3_ff <= ref_s2_ff;
    end
  end
  assign ref_edge = ref_s2_ff ^ ref_s3_ff;

  // Bus cycles between reference edges; too few means the clock is too slow.
  // A fully stopped clock cannot be seen from its own domain; stop_i covers that case.
  assign cm_slow = cm_en && ref_edge && (cm_gap_ff < wcm_pkg::CM_MIN_CYC); // see R10
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !cm_en) begin
      cm_gap_ff <= wcm_pkg::CM_GAP_MAX; // First edge after enabling never trips
    end else if (ref_edge) begin
      cm_gap_ff <= 4'h0;
    end else if (cm_gap_ff != wcm_pkg::CM_GAP_MAX) begin
      cm_gap_ff <= cm_gap_ff + 4'h1; // see R9
    end
  end
  assign cm_fail = cm_slow || (cm_en && stop_i); // see R13

  // Internal reset pulse, three cycles low; new failures during a pulse merge into it
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pulse_cnt_ff <= 2'h0;
      rst_n_o <= 1'b1;
    end else if (pulse_cnt_ff != 2'h0) begin
      pulse_cnt_ff <= pulse_cnt_ff - 2'h1;
      rst_n_o <= (pulse_cnt_ff == 2'h1);
    end else if (wdt_fail || cm_fail) begin
      pulse_cnt_ff <= wcm_pkg::RST_PULSE_CYC; // see R14
      rst_n_o <= 1'b0; // see R1
    end
  end

  // Failure causes; a new failure wins over an acknowledge in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wdt_cause_o <= 1'b0;
      cm_cause_o <= 1'b0;
    end else begin
      wdt_cause_o <= wdt_fail || (wdt_cause_o && !cause_ack_i); // see R14
      cm_cause_o <= cm_fail || (cm_cause_o && !cause_ack_i); // see R14
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_rst_pulse_len: assert property ($fell(rst_n_o) |-> !rst_n_o [*3] ##1 rst_n_o) // see R14
    else $error("reset pulse not three cycles");
  a_sel_locked: assert property (!boot_open && $past(!boot_open) |-> $stable(opt_ff.sel)) // see R3
    else $error("select changed after window");
  a_force_holds: assert property (opt_ff.clock_watch_force_enable |=> opt_ff.clock_watch_force_enable && cm_en) // see R12
    else $error("force enable dropped");
  a_disabled_quiet: assert property (dis_ff |=> !wdt_cause_o || $past(wdt_cause_o)) // see R4
    else $error("watchdog fired while disabled");
  a_stop_reset: assert property (stop_i && cm_en && pulse_cnt_ff == 2'h0 |=> !rst_n_o && cm_cause_o) // see R13
    else $error("stop did not reset");
  a_expire_reset: assert property (expired && !dis_ff && pulse_cnt_ff == 2'h0 |=> !rst_n_o && wdt_cause_o) // see R1
    else $error("timeout did not reset");
  a_lone_fire: assert property (svc_wr_i && svc_data_i == wcm_pkg::SVC_FIRE && !armed_ff |=> !armed_ff && !$past(restart)) // see R15
    else $error("unarmed service restarted");
  a_fire_restart: assert property (restart |=> !armed_ff ##1 !expired) // see R8
    else $error("service did not restart period");
  a_nv_capture: assert property (!cap_done_ff |=> dis_ff == $past(nv_disable_i)) // see R6
    else $error("disable bit not restored");
  a_slow_clock: assert property (cm_slow && pulse_cnt_ff == 2'h0 |=> !rst_n_o && cm_cause_o) // see R10
    else $error("slow clock not caught");
  a_period_sel: assert property (opt_ff.sel == 2'h1 |-> limit == WDT_CYC1) // see R2
    else $error("wrong period selected");

endmodule : wcm_top
`default_nettype wire

/* File: verification/wcm_top_test.sv */
// Self-checking bench for the watchdog and clock monitor, periods shortened.
// Assumes wcm_top guards its own assertions; the bench drives every port.
`timescale 1ns/1ns
`default_nettype none
module wcm_top_test;
  logic core_clk_i, rst_i, svc_wr_i, opt_wr_i, cfg_wr_i, cfg_disable_i, nv_disable_i;
  logic stop_i, ref_osc_i, cause_ack_i, rst_n_o, wdt_cause_o, cm_cause_o, disable_o;
  logic svc_armed_o, boot_open_o, nv_wr_o, nv_data_o;
  logic [7:0] svc_data_i;
  wcm_pkg::wcm_opt_t opt_wdata_i, opt_o;
  int num_errors = 0, tests_run = 0, cycles = 0, lows = 0, n, k, lim;
  int seed = 32'h8d1caa91;
  localparam int LIM [4] = '{32'h14, 32'h28, 32'h50, 32'ha0};

  wcm_top #(.WDT_CYC0(32'h14), .WDT_CYC1(32'h28), .WDT_CYC2(32'h50), .WDT_CYC3(32'ha0)) wcm_top_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .svc_wr_i(svc_wr_i), .svc_data_i(svc_data_i),
    .opt_wr_i(opt_wr_i), .opt_wdata_i(opt_wdata_i), .cfg_wr_i(cfg_wr_i), .cfg_disable_i(cfg_disable_i),
    .nv_disable_i(nv_disable_i), .stop_i(stop_i), .ref_osc_i(ref_osc_i), .cause_ack_i(cause_ack_i),
    .rst_n_o(rst_n_o), .wdt_cause_o(wdt_cause_o), .cm_cause_o(cm_cause_o), .opt_o(opt_o),
    .disable_o(disable_o), .svc_armed_o(svc_armed_o), .boot_open_o(boot_open_o),
    .nv_wr_o(nv_wr_o), .nv_data_o(nv_data_o));

  // Clock, 10 ns period
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Cycle ceiling and count of reset-request cycles, so silent periods can be proven
  always @(posedge core_clk_i) begin
    cycles++;
    if (rst_n_o === 1'b0) lows++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Edges from the restarting strobe to the first low reset sample: the period plus the output register
  function automatic int wdt_span(input int lim);
    return lim + 1;
  endfunction : wdt_span

  task automatic tick(input int c);
    repeat (c) @(negedge core_clk_i);
  endtask : tick

  task automatic do_reset(input logic nv);
    nv_disable_i = nv;
    rst_i = 1'b1;
    tick(2);
    rst_i = 1'b0;
    tick(1);
  endtask : do_reset

  task automatic svc(input logic [7:0] b);
    svc_wr_i = 1'b1;
    svc_data_i = b;
    tick(1);
    svc_wr_i = 1'b0;
    tick(1); // Strobe drops for a full cycle so back-to-back writes stay distinct
  endtask : svc

  task automatic opt(input logic [3:0] v, input logic [3:0] exp);
    opt_wr_i = 1'b1;
    opt_wdata_i = v;
    tick(1);
    opt_wr_i = 1'b0;
    tick(1);
    check("opt", opt_o, exp);
  endtask : opt

  task automatic cfg(input logic v);
    cfg_wr_i = 1'b1;
    cfg_disable_i = v;
    tick(1);
    cfg_wr_i = 1'b0;
    check("nv_wr", nv_wr_o, 1'b1);
    check("nv_data", nv_data_o, v);
    check("disable", disable_o, v);
  endtask : cfg

  // Waits up to max cycles for a reset request, then checks its length
  task automatic wait_rst(input int max, output int c);
    int w;
    c = 0;
    w = 0;
    while (rst_n_o !== 1'b0 && c < max) begin
      tick(1);
      c++;
    end
    while (rst_n_o === 1'b0 && w < 8) begin
      tick(1);
      w++;
    end
    if (c < max) check("pulse", w, 3);
  endtask : wait_rst

  task automatic stop_run(input int max, output int c);
    stop_i = 1'b1;
    tick(1);
    stop_i = 1'b0;
    wait_rst(max, c);
    tick(3);
  endtask : stop_run

  initial begin
    {rst_i, svc_wr_i, opt_wr_i, cfg_wr_i, cfg_disable_i, stop_i, ref_osc_i, cause_ack_i} = '0;
    svc_data_i = 8'h00;
    opt_wdata_i = '0;
    do_reset(1'b1);
    check("opt rst", opt_o, wcm_pkg::OPT_RST);
    check("disable rst", disable_o, 1'b1);
    check("boot_open", boot_open_o, 1'b1);
    // Select locks after the window; enable stays free; force is set-only
    opt(4'h8, 4'h8);
    tick(70);
    check("boot_open", boot_open_o, 1'b0);
    opt(4'h6, 4'ha);
    opt(4'h9, 4'h9);
    opt(4'h0, 4'h9);
    // Each period, with a lone closing byte in mid-period that must not restart
    for (int s = 0; s < 4; s++) begin
      do_reset(1'b0);
      opt({s[1:0], 2'h0}, {s[1:0], 2'h0});
      svc(8'h55);
      check("armed", svc_armed_o, 1'b1);
      svc(8'haa);
      check("armed", svc_armed_o, 1'b0);
      lim = LIM[s];
      tick(lim / 2);
      svc(8'haa);
      wait_rst(2 * lim, n);
      check("period", n + lim / 2 + 3, wdt_span(lim));
      check("wdt_cause", {wdt_cause_o, cm_cause_o}, 2'h2);
    end
    // Random servicing with stray bytes between the pair keeps reset away
    do_reset(1'b0);
    opt(4'hc, 4'hc);
    k = lows;
    for (int i = 0; i < 20; i++) begin
      svc(8'h55);
      repeat ($unsigned($random(seed)) % 6) svc(8'h30 | 8'($unsigned($random(seed)) % 16));
      svc(8'haa);
      tick($unsigned($random(seed)) % 40);
    end
    check("serviced", lows - k, 0);
    cfg(1'b1);
    wait_rst(400, n);
    check("disabled", n, 400);
    cfg(1'b0);
    // Clock monitor: slow-enough reference stays quiet, a short gap trips
    do_reset(1'b1);
    opt(4'h2, 4'h2);
    k = lows;
    for (int i = 0; i < 30; i++) begin
      tick(7 + $unsigned($random(seed)) % 9);
      ref_osc_i = ~ref_osc_i;
    end
    check("cm quiet", lows - k, 0);
    tick(2);
    ref_osc_i = ~ref_osc_i;
    wait_rst(10, n);
    check("cm trip", n < 10, 1'b1);
    check("cm_cause", {wdt_cause_o, cm_cause_o}, 2'h1);
    cause_ack_i = 1'b1;
    tick(1);
    cause_ack_i = 1'b0;
    tick(1);
    check("ack", cm_cause_o, 1'b0);
    stop_run(5, n);
    check("stop trip", n < 5, 1'b1);
    opt(4'h0, 4'h0);
    stop_run(20, n);
    check("stop off", n, 20);
    opt(4'h1, 4'h1);
    stop_run(5, n);
    check("forced", n < 5, 1'b1);
    test_done();
  end
endmodule : wcm_top_test
`default_nettype wire
